//--- logic/wrtc_top.sv
// run-mode and trigger controller with AHB-Lite register slave
// Functional notes
// RULE_01: continuous mode replays the waveform back to back while run is on.
// RULE_02: reset selects continuous mode.
// RULE_03: remote run-on and run-off commands start and halt continuous playback.
// RULE_04: a newly written mode takes effect immediately.
// RULE_05: triggered mode holds DC until a valid trigger.
// RULE_06: each valid trigger plays exactly one full waveform pass.
// RULE_07: after a triggered or gated cycle, output holds the last sample.
// RULE_08: hardware source takes rear input and manual button, ignores remote.
// RULE_09: remote source takes only remote commands.
// RULE_10: mixed source waits for a remote trigger, then also accepts hardware. Here only the rear input is accepted once armed, not the manual button.
// RULE_11: positive slope triggers on rising crossing, negative on falling.
// RULE_12: triggered mode works for every waveform type.
// RULE_13: enabled delay suppresses output for the programmed delay after a trigger.
// RULE_14: delay minimum 200 ns, 20 ns steps, range beyond 20 s.
// RULE_15: re-trigger waits for a trigger, then issues repeating internal triggers.
// RULE_16: re-trigger interval runs from end of one pass to next start.
// RULE_17: re-trigger interval 200 ns minimum to beyond 20 s in 20 ns steps.
// RULE_18: gated mode idles until gate-on edge, gates off on opposite edge.
// RULE_19: after gate-off the pass in progress completes before DC hold.
// RULE_20: gating comes only from the rear hardware input.
// RULE_21: the rear input passes a two-stage synchroniser before edge detection.
// RULE_22: delay and re-trigger timers are down-counters in 20 ns ticks.
`timescale 1ns/1ns
`default_nettype none
module wrtc_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic rear_trigger_input,
   input wire logic front_manual_trigger_button,
   input wire logic pass_done,
   output var wrtc_pkg::wrtc_play_t play
);
   import wrtc_pkg::*;

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   logic [31:0] ctrl;
   logic [31:0] delay_ticks;
   logic [31:0] retrig_ticks;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic cmd_trig;
   logic cmd_on;
   logic cmd_off;
   logic addr_ok;
   logic wr_cmd;
   wrtc_mode_t mode;
   wrtc_src_t src;
   logic slope_neg;
   logic active;

   assign addr_ok = hsel && hready && htrans[1];
   assign wr_cmd = wr_pend && (wr_addr == ADDR_CMD);
   assign cmd_trig = wr_cmd && hwdata[CMD_TRIG_BIT];
   assign cmd_on = wr_cmd && hwdata[CMD_RUN_ON_BIT];
   assign cmd_off = wr_cmd && hwdata[CMD_RUN_OFF_BIT];
   assign mode = wrtc_mode_t'(ctrl[CTRL_MODE_LSB +: 2]);
   assign src = wrtc_src_t'(ctrl[CTRL_SRC_LSB +: 2]);
   assign slope_neg = ctrl[CTRL_SLOPE_BIT];

   // interval below the floor is raised to it
   function automatic logic [31:0] clamp_ticks(input logic [31:0] v);
      clamp_ticks = (v < MIN_TICKS) ? MIN_TICKS : v;
   endfunction : clamp_ticks

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         wr_pend <= addr_ok && hwrite;
         wr_addr <= haddr[7:0];
         if (addr_ok && !hwrite) begin
            case (haddr[7:0])
               ADDR_CTRL: hrdata <= ctrl;
               ADDR_DELAY: hrdata <= delay_ticks;
               ADDR_RETRIG: hrdata <= retrig_ticks;
               ADDR_STATUS: hrdata <= {30'h0000_0000, play.hold, active};
               default: hrdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // mode writes land at once, no staging register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= CTRL_RESET; // RULE_02
         delay_ticks <= MIN_TICKS;
         retrig_ticks <= MIN_TICKS;
      end else begin
         if (wr_pend && wr_addr == ADDR_CTRL) begin
            ctrl <= {24'h00_0000, hwdata[7:0]}; // RULE_04
         end else if (cmd_on) begin
            ctrl[CTRL_RUN_BIT] <= 1'b1; // RULE_03
         end else if (cmd_off) begin
            ctrl[CTRL_RUN_BIT] <= 1'b0; // RULE_03
         end
         if (wr_pend && wr_addr == ADDR_DELAY) begin
            delay_ticks <= clamp_ticks(hwdata); // RULE_14
         end
         if (wr_pend && wr_addr == ADDR_RETRIG) begin
            retrig_ticks <= clamp_ticks(hwdata); // RULE_17
         end
      end
   end

   // ---------------------------------------------------------------
   // trigger input path
   // ---------------------------------------------------------------
   logic [1:0] rear_sync;
   logic [1:0] man_sync;
   logic rear_d;
   logic man_d;
   logic rear_lvl;
   logic rear_edge_on;
   logic rear_edge_off;
   logic man_edge;
   logic mixed_armed;
   logic valid_trig;
   // both pins are asynchronous to hclk; only the second stage feeds logic,
   // so a metastable first stage never reaches the edge detectors

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rear_sync <= 2'b00;
         man_sync <= 2'b00;
         rear_d <= 1'b0;
         man_d <= 1'b0;
      end else begin
         rear_sync <= {rear_sync[0], rear_trigger_input}; // RULE_21
         man_sync <= {man_sync[0], front_manual_trigger_button};
         rear_d <= rear_sync[1];
         man_d <= man_sync[1];
      end
   end

   assign rear_lvl = rear_sync[1] ^ slope_neg;
   assign rear_edge_on = rear_lvl && !(rear_d ^ slope_neg); // RULE_11
   assign rear_edge_off = !rear_lvl && (rear_d ^ slope_neg);
   assign man_edge = man_sync[1] && !man_d;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mixed_armed <= 1'b0;
      end else if (src != WRTC_SRC_MIXED) begin
         mixed_armed <= 1'b0;
      end else if (cmd_trig) begin
         mixed_armed <= 1'b1; // RULE_10
      end
   end

   always_comb begin
      case (src)
         WRTC_SRC_HW: valid_trig = rear_edge_on || man_edge; // RULE_08
         WRTC_SRC_REMOTE: valid_trig = cmd_trig; // RULE_09
         WRTC_SRC_MIXED: valid_trig = cmd_trig || (mixed_armed && rear_edge_on); // RULE_10
         default: valid_trig = 1'b0;
      endcase
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {ST_IDLE, ST_DELAY, ST_PLAY, ST_GAP, ST_CONT} wrtc_state_t;
   wrtc_state_t state;
   logic [31:0] timer;
   logic gate_on;
   logic trig_mode;
   logic timer_done;
   logic start_pulse;

   // counted burst is out of scope here: it behaves as a single pass per trigger
   assign trig_mode = (mode == WRTC_TRIG) || (mode == WRTC_BURST);
   // one clock is several 20 ns ticks, so intervals resolve to a whole clock;
   // the timer ends when no more than one clock of ticks is left
   assign timer_done = (timer <= TICK_STEP);
   assign active = (state != ST_IDLE);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gate_on <= 1'b0;
      end else if (mode != WRTC_GATE) begin
         gate_on <= 1'b0;
      end else if (rear_edge_on) begin
         gate_on <= 1'b1; // RULE_18 RULE_20
      end else if (rear_edge_off) begin
         gate_on <= 1'b0; // RULE_18
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= ST_IDLE;
         timer <= 32'h0000_0000;
         start_pulse <= 1'b0;
      end else begin
         start_pulse <= 1'b0;
         case (state)
            ST_IDLE: begin
               if (mode == WRTC_CONT && ctrl[CTRL_RUN_BIT]) begin
                  state <= ST_CONT;
                  start_pulse <= 1'b1; // RULE_01
               end else if (trig_mode && valid_trig) begin
                  if (ctrl[CTRL_DLY_EN_BIT]) begin
                     state <= ST_DELAY; // RULE_13
                     timer <= delay_ticks; // RULE_22
                  end else begin
                     state <= ST_PLAY; // RULE_06 RULE_12
                     start_pulse <= 1'b1;
                  end
               end else if (mode == WRTC_GATE && gate_on) begin
                  state <= ST_PLAY;
                  start_pulse <= 1'b1;
               end
            end
            ST_DELAY: begin
               if (!trig_mode) begin
                  state <= ST_IDLE;
               end else if (timer_done) begin
                  state <= ST_PLAY;
                  start_pulse <= 1'b1;
               end else begin
                  timer <= timer - TICK_STEP; // RULE_22
               end
            end
            ST_PLAY: begin
               if (pass_done) begin
                  if (mode == WRTC_GATE && gate_on) begin
                     start_pulse <= 1'b1; // RULE_19
                  end else if (trig_mode && ctrl[CTRL_RTRG_EN_BIT]) begin
                     state <= ST_GAP; // RULE_15 RULE_16
                     timer <= retrig_ticks;
                  end else begin
                     state <= ST_IDLE; // RULE_07
                  end
               end
            end
            ST_GAP: begin
               if (!trig_mode || !ctrl[CTRL_RTRG_EN_BIT]) begin
                  state <= ST_IDLE;
               end else if (timer_done) begin
                  state <= ST_PLAY;
                  start_pulse <= 1'b1;
               end else begin
                  timer <= timer - TICK_STEP; // RULE_16
               end
            end
            ST_CONT: begin
               if (mode != WRTC_CONT || !ctrl[CTRL_RUN_BIT]) begin
                  state <= ST_IDLE; // RULE_03 RULE_04
               end else if (pass_done) begin
                  start_pulse <= 1'b1; // RULE_01
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // outputs straight from flops: hold = sit on last sample (or DC idle)
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         play <= '{start: 1'b0, hold: 1'b1, run: 1'b0};
      end else begin
         play.start <= start_pulse;
         play.hold <= (state == ST_IDLE) || (state == ST_DELAY) || (state == ST_GAP); // RULE_05
         play.run <= (state == ST_PLAY) || (state == ST_CONT);
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   a_reset_mode_cont: assert property (@(posedge hclk) $rose(hresetn) |-> mode == WRTC_CONT) // RULE_02
      else $error("mode not continuous after reset");
   a_remote_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
      (src == WRTC_SRC_HW && state == ST_IDLE && trig_mode && !rear_edge_on && !man_edge)
      |=> state == ST_IDLE) // RULE_08
      else $error("hardware source started without hardware edge");
   a_hw_blocked: assert property (@(posedge hclk) disable iff (!hresetn)
      (src == WRTC_SRC_REMOTE && state == ST_IDLE && trig_mode && !cmd_trig)
      |=> state == ST_IDLE) // RULE_09
      else $error("remote source started without command");
   a_mixed_arm: assert property (@(posedge hclk) disable iff (!hresetn)
      (src == WRTC_SRC_MIXED && !mixed_armed && !cmd_trig && state == ST_IDLE && trig_mode)
      |=> state == ST_IDLE) // RULE_10
      else $error("mixed source fired before first remote trigger");
   a_trig_hold_dc: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == ST_IDLE) |=> play.hold) // RULE_05
      else $error("output not held while idle");
   a_delay_floor: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == ST_IDLE && trig_mode && valid_trig && ctrl[CTRL_DLY_EN_BIT])
      |=> state == ST_DELAY ##1 state == ST_DELAY) // RULE_13
      else $error("delay shorter than minimum");
   a_one_pass: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == ST_PLAY && pass_done && mode == WRTC_TRIG && !ctrl[CTRL_RTRG_EN_BIT])
      |=> state == ST_IDLE ##1 play.hold) // RULE_06
      else $error("triggered pass did not stop after one pass");
   a_gate_finish: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == ST_PLAY && mode == WRTC_GATE && !pass_done) |=> state == ST_PLAY) // RULE_19
      else $error("gated pass cut short");
   a_cont_off: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == ST_CONT && !ctrl[CTRL_RUN_BIT]) |=> state == ST_IDLE ##1 !play.run) // RULE_03
      else $error("continuous output did not stop");

   // ---------------------------------------------------------------
   // checks: timers, gating, continuous repeat and bus response
   // ---------------------------------------------------------------
   // the slave never stalls and never errors; a wait state would stretch
   // the one-cycle command strobe that the remote trigger relies on
   a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp)
      else $error("bus slave stalled or answered with an error");
   // no start may leak out while the delay is still counting
   a_delay_quiet: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_13
      (state == ST_DELAY && trig_mode && !timer_done) |=> !start_pulse && state == ST_DELAY)
      else $error("output started before the delay ran out");
   a_timer_step: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_22
      (state == ST_DELAY && trig_mode && !timer_done) |=> timer == $past(timer) - TICK_STEP)
      else $error("delay timer did not step down by one clock of ticks");
   // the gap is loaded at the end of a pass, not at its start
   a_gap_load: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_15 RULE_16
      (state == ST_PLAY && pass_done && trig_mode && ctrl[CTRL_RTRG_EN_BIT])
      |=> state == ST_GAP && timer == $past(retrig_ticks))
      else $error("re-trigger gap not loaded at end of pass");
   a_gap_quiet: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_16
      (state == ST_GAP && trig_mode && ctrl[CTRL_RTRG_EN_BIT] && !timer_done) |=> !start_pulse)
      else $error("internal trigger fired before the gap ran out");
   a_interval_floor: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_14 RULE_17
      (delay_ticks >= MIN_TICKS) && (retrig_ticks >= MIN_TICKS))
      else $error("programmed interval below the minimum");
   a_cont_repeat: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_01
      (state == ST_CONT && mode == WRTC_CONT && ctrl[CTRL_RUN_BIT] && pass_done)
      |=> start_pulse && state == ST_CONT)
      else $error("continuous pass not restarted back to back");
   // remote commands must not open the gate: only the rear edge may
   a_gate_wait: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_18 RULE_20
      (state == ST_IDLE && mode == WRTC_GATE && !gate_on) |=> state == ST_IDLE)
      else $error("gated output started with the gate closed");
   a_gate_drop: assert property (@(posedge hclk) disable iff (!hresetn) // RULE_18
      (mode == WRTC_GATE && rear_edge_off) |=> !gate_on)
      else $error("gate stayed open after the gate-off edge");
endmodule : wrtc_top
`default_nettype wire

//--- logic/wrtc_pkg.sv
// package: register map, field layout and timing for the run-mode trigger controller
package wrtc_pkg;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_DELAY = 8'h04;
   localparam logic [7:0] ADDR_RETRIG = 8'h08;
   localparam logic [7:0] ADDR_CMD = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   // ---------------------------------------------------------------
   // control field positions
   // ---------------------------------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_SRC_LSB = 2;
   localparam int CTRL_SLOPE_BIT = 4;
   localparam int CTRL_DLY_EN_BIT = 5;
   localparam int CTRL_RTRG_EN_BIT = 6;
   localparam int CTRL_RUN_BIT = 7;
   localparam int CMD_TRIG_BIT = 0;
   localparam int CMD_RUN_ON_BIT = 1;
   localparam int CMD_RUN_OFF_BIT = 2;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0080;
   // ---------------------------------------------------------------
   // timing: 20 ns ticks, 200 ns minimum, counts wide enough for > 20 s
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 100;
   localparam int TICK_NS = 20;
   localparam int MIN_INTERVAL_NS = 200;
   localparam int TICKS_PER_CLK = CLK_PERIOD_NS / TICK_NS;
   localparam int CNT_W = 32;
   localparam logic [CNT_W-1:0] MIN_TICKS = CNT_W'(MIN_INTERVAL_NS / TICK_NS);
   localparam logic [CNT_W-1:0] TICK_STEP = CNT_W'(TICKS_PER_CLK);
   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {WRTC_CONT, WRTC_TRIG, WRTC_GATE, WRTC_BURST} wrtc_mode_t;
   typedef enum logic [1:0] {WRTC_SRC_HW, WRTC_SRC_REMOTE, WRTC_SRC_MIXED,
      WRTC_SRC_RSVD} wrtc_src_t;
   typedef struct packed {
      logic start;
      logic hold;
      logic run;
   } wrtc_play_t;
endpackage : wrtc_pkg

//--- verification/wrtc_play_engine.sv
// playback engine model: answers each start with one pass_done pulse
`timescale 1ns/1ns
`default_nettype none
module wrtc_play_engine (
   input wire logic hclk,
   input wire logic hresetn,
   input wire wrtc_pkg::wrtc_play_t play,
   input wire logic [7:0] pass_len,
   output logic pass_done
);
   import wrtc_pkg::*;
   logic [7:0] cnt;
   logic busy;
   // pass length comes from the bench so a pass can be short or long
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy <= 1'b0;
         cnt <= 8'h00;
         pass_done <= 1'b0;
      end else begin
         pass_done <= 1'b0;
         if (play.start) begin
            busy <= 1'b1;
            cnt <= pass_len;
         end else if (busy) begin
            if (cnt <= 8'h01) begin
               busy <= 1'b0;
               pass_done <= 1'b1;
            end
            cnt <= cnt - 8'h01;
         end
      end
   end
endmodule : wrtc_play_engine
`default_nettype wire

//--- verification/tb_top.sv
// self-checking testbench for the run-mode trigger controller
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import wrtc_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic rear = 1'b0;
   logic button = 1'b0;
   logic [7:0] pass_len = 8'h08;
   logic hreadyout, hresp, pass_done;
   logic [31:0] hrdata, rd;
   wrtc_play_t play;
   int errors = 0, checked = 0, starts = 0, holds = 0, s0;
   longint tstart, tdone, t0;
   wrtc_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .rear_trigger_input(rear), .front_manual_trigger_button(button),
      .pass_done(pass_done), .play(play));
   wrtc_play_engine i_eng (.hclk(hclk), .hresetn(hresetn), .play(play),
      .pass_len(pass_len), .pass_done(pass_done));
   initial forever #50 hclk = ~hclk;
   // -------------------------------------------------------------
   // monitors and shared tasks
   // -------------------------------------------------------------
   // sampled mid-cycle, where registered outputs have settled
   always @(negedge hclk) begin
      if (play.start === 1'b1) begin
         starts = starts + 1;
         tstart = $time;
      end
      if (pass_done === 1'b1) tdone = $time;
      if (play.hold === 1'b1) holds = holds + 1;
   end
   task test_done;
      if (errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked = checked + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask : cyc
   task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
      chk({31'h0000_0000, hresp}, 32'h0000_0000);
   endtask : ahb
   task wait_start(input int lim);
      int i, s;
      s = starts;
      i = 0;
      while (starts == s && i < lim) begin
         @(posedge hclk);
         i = i + 1;
      end
   endtask : wait_start
   // 0 remote command, 1 rear rise, 2 rear fall, 3 button press
   task fire(input int how);
      case (how)
         0: ahb(1'b1, ADDR_CMD, 32'h0000_0001);
         1: rear <= 1'b1;
         2: rear <= 1'b0;
         default: begin
            button <= 1'b1;
            cyc(5);
            button <= 1'b0;
         end
      endcase
      t0 = $time;
   endtask : fire
   task trig_exp(input int how, input int n);
      s0 = starts;
      fire(how);
      cyc(40);
      chk(32'(starts - s0), 32'(n));
   endtask : trig_exp
   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task t_cont;
      ahb(1'b0, ADDR_CTRL, 32'h0000_0000);
      chk(rd, CTRL_RESET);
      ahb(1'b0, 8'h14, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      ahb(1'b0, ADDR_CMD, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      pass_len <= 8'h02;
      s0 = starts;
      holds = 0;
      cyc(60);
      chk(32'(starts - s0 > 6), 32'h0000_0001);
      chk(32'(holds), 32'h0000_0000);
      pass_len <= 8'h08;
   endtask : t_cont
   task t_run;
      ahb(1'b1, ADDR_CMD, 32'h0000_0004);
      cyc(30);
      chk({30'h0000_0000, play.run, play.hold}, 32'h0000_0001);
      s0 = starts;
      cyc(20);
      chk(32'(starts - s0), 32'h0000_0000);
      ahb(1'b1, ADDR_CMD, 32'h0000_0002);
      cyc(5);
      chk(32'(starts - s0), 32'h0000_0001);
      ahb(1'b0, ADDR_STATUS, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
   endtask : t_run
   task t_trig;
      for (int m = 1; m < 4; m = m + 2) begin
         ahb(1'b1, ADDR_CTRL, 32'(m) | 32'h0000_0004);
         cyc(20);
         chk({31'h0000_0000, play.hold}, 32'h0000_0001);
         s0 = starts;
         cyc(30);
         chk(32'(starts - s0), 32'h0000_0000);
         trig_exp(0, 1);
         chk({31'h0000_0000, play.hold}, 32'h0000_0001);
      end
   endtask : t_trig
   task t_src;
      int c[14] = '{1, 1, 1, 1, 17, 17, 5, 5, 5, 5, 9, 9, 9, 9};
      int h[14] = '{0, 1, 2, 3, 1, 2, 1, 2, 3, 0, 1, 2, 0, 1};
      int n[14] = '{0, 1, 0, 1, 0, 1, 0, 0, 0, 1, 0, 0, 1, 1};
      foreach (c[k]) begin
         if (k == 0 || c[k] != c[k - 1]) ahb(1'b1, ADDR_CTRL, 32'(c[k]));
         trig_exp(h[k], n[k]);
         if (k == 1) chk(32'(tstart - t0 >= 250 && tstart - t0 <= 700), 32'h0000_0001);
      end
   endtask : t_src
   task t_delay;
      int d[3] = '{0, 50, 1000};
      int e;
      ahb(1'b1, ADDR_CTRL, 32'h0000_0025);
      foreach (d[k]) begin
         e = (d[k] < 10 ? 10 : d[k]) * 20;
         ahb(1'b1, ADDR_DELAY, 32'(d[k]));
         fire(0);
         wait_start(400);
         chk(32'(tstart - t0 >= e - 100), 32'h0000_0001);
         chk(32'(tstart - t0 <= e + 600), 32'h0000_0001);
         cyc(20);
      end
   endtask : t_delay
   task t_retrig;
      ahb(1'b1, ADDR_RETRIG, 32'h0000_0064);
      ahb(1'b1, ADDR_CTRL, 32'h0000_0045);
      s0 = starts;
      cyc(40);
      chk(32'(starts - s0), 32'h0000_0000);
      fire(0);
      wait_start(20);
      repeat (2) begin
         wait_start(100);
         chk(32'(tstart - tdone >= 1900 && tstart - tdone <= 2600), 32'h0000_0001);
      end
      ahb(1'b1, ADDR_CTRL, 32'h0000_0005);
      cyc(60);
      s0 = starts;
      cyc(40);
      chk(32'(starts - s0), 32'h0000_0000);
   endtask : t_retrig
   task t_gate;
      rear <= 1'b0;
      ahb(1'b1, ADDR_CTRL, 32'h0000_0002);
      s0 = starts;
      fire(0);
      cyc(30);
      chk(32'(starts - s0), 32'h0000_0000);
      rear <= 1'b1;
      cyc(50);
      chk(32'(starts - s0 >= 3), 32'h0000_0001);
      wait_start(20);
      cyc(2);
      rear <= 1'b0;
      cyc(5);
      chk({31'h0000_0000, play.run}, 32'h0000_0001);
      cyc(20);
      s0 = starts;
      cyc(30);
      chk({31'h0000_0000, play.hold}, 32'h0000_0001);
      chk(32'(starts - s0), 32'h0000_0000);
   endtask : t_gate
   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_cont();
      t_run();
      t_trig();
      t_src();
      t_delay();
      t_retrig();
      t_gate();
      test_done();
   end
   // the whole sequence needs well under a third of this span
   initial begin
      #2_000_000;
      errors = errors + 1;
      test_done();
   end
endmodule : tb_top
`default_nettype wire
